// file: stm_params.svh
// constants for the 10-bit standard timer: register offsets, field positions,
// reset values and clock-divider counts
// assumes a word-aligned classic wishbone slave with 32-bit data
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH

// -------------------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------------------
`define STM_OFS_CTRL0 6'h00
`define STM_OFS_CTRL1 6'h04
`define STM_OFS_CNT_LO 6'h08
`define STM_OFS_CNT_HI 6'h0C
`define STM_OFS_CMPA_LO 6'h10
`define STM_OFS_CMPA_HI 6'h14
`define STM_OFS_STATUS 6'h18

// -------------------------------------------------------------------------
// field positions and control reset value
// -------------------------------------------------------------------------
`define STM_C0_PAUSE 7
`define STM_C0_ON 3
`define STM_RST_CTRL 8'h00

// -------------------------------------------------------------------------
// prescale counts for the internal clock choices, period step and full period
// -------------------------------------------------------------------------
`define STM_DIV_SYS4 8'h04
`define STM_DIV_H16 8'h10
`define STM_DIV_H64 8'h40
`define STM_PERIOD_STEP 11'h080
`define STM_FULL_PERIOD 11'h400

`endif

// file: stm_pkg.sv
// types for the 10-bit standard timer
// assumes stm_params.svh supplies the numeric constants
package stm_pkg;

  // -----------------------------------------------------------------------
  // mode enumeration
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {
    STM_MODE_CMP,
    STM_MODE_CAP,
    STM_MODE_PWM,
    STM_MODE_TMR
  } stm_mode_e;

  // control register 0 layout
  typedef struct packed {
    logic pause_control;
    logic [2:0] clock_select;
    logic timer_on_control;
    logic [2:0] period_field;
  } stm_ctrl0_s;

  // control register 1 layout
  typedef struct packed {
    stm_mode_e mode_field;
    logic [1:0] pin_action_field;
    logic output_control_bit;
    logic polarity_bit;
    logic duty_period_swap;
    logic clear_select;
  } stm_ctrl1_s;

  // timer pins grouped
  typedef struct packed {
    logic timer_output_pin;
    logic complementary_output_pin;
  } stm_pins_s;

endpackage : stm_pkg

// file: stm_timer.sv
// 10-bit standard timer with classic wishbone register slave
// assumes asynchronous pins and separate high/sub clock tick strobes in clk_i domain
//
// Overview of operation
// - ten-bit up counter on selected clock
// - period compares counter bits nine to seven
// - on rising clears count; off holds count
// - pause freezes count, resume continues
// - clock select picks source or pin edge
// - period match every field times 128, 1024 when field is zero
// - two-bit mode field picks operating mode
// - compare match: none, low, high, toggle
// - pwm: inactive, active, pwm, single pulse
// - capture rising, falling, both, or disabled
// - turn-on restores output initial level in compare mode
// - same level request gives no change
// - output control sets pwm active level
// - polarity bit inverts output pin outside timer counter mode
// - swap bit exchanges period and duty
// - clear on compare a or period
// - clear select ignored in pwm, capture
// - timer counter mode holds the last raw output level on the pin
// - interrupt request on automatic clear
// - complementary pin is inverse output
// - low bytes go through holding buffer
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "stm_params.svh"

module stm_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic high_tick_i,
  input wire logic sub_tick_i,
  input wire logic external_clock_pin_i,
  input wire logic capture_input_pin_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output stm_pkg::stm_pins_s pins_o,
  output logic irq_a_o,
  output logic irq_p_o
);
  import stm_pkg::*;

  // -----------------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------------
  stm_ctrl0_s c0_q; // control 0
  stm_ctrl1_s c1_q; // control 1
  logic [9:0] cnt_q; // main counter
  logic [9:0] cmpa_q; // compare a value
  logic [7:0] hold_q; // low byte holding buffer
  logic [9:0] cap_q; // not separate: capture loads compare a
  logic on_d1_q; // previous on level
  logic out_q; // raw output level
  logic pulse_q; // single pulse running
  logic [7:0] pre_q; // prescaler
  logic [2:0] ext_q; // external clock sync and edge
  logic [2:0] capin_q; // capture sync and edge
  logic ack_q; // bus answer

  logic on_rise; // on control rising edge
  logic tick; // timer clock event
  logic match_a; // comparator a match
  logic match_p; // comparator p match
  logic clr_a; // counter cleared by a
  logic clr_p; // counter cleared by p or overflow
  logic cap_ev; // qualifying capture edge
  logic wr; // bus write accepted
  logic rd; // bus read accepted
  logic [7:0] rdat; // read byte
  logic [10:0] per_len; // period length in clocks
  logic [10:0] duty_len; // duty length in clocks
  logic pwm_act; // pwm active phase
  logic [7:0] div; // chosen prescale
  logic irq_run; // counter running and enabled this cycle

  assign on_rise = c0_q.timer_on_control & ~on_d1_q;
  assign wr = cyc_i & stb_i & we_i & ~ack_q & sel_i[0];
  assign rd = cyc_i & stb_i & ~we_i & ~ack_q;

  // -----------------------------------------------------------------------
  // input synchronisers: stage 0 only feeds stage 1
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_q <= 3'h0;
      capin_q <= 3'h0;
    end else if (ce_i) begin
      ext_q <= {ext_q[1:0], external_clock_pin_i};
      capin_q <= {capin_q[1:0], capture_input_pin_i};
    end
  end

  // -----------------------------------------------------------------------
  // clock source selection
  // -----------------------------------------------------------------------
  // the prescaler counts clk_i under select 0 and high_tick_i under every other select
  always_comb begin
    div = `STM_DIV_SYS4;
    tick = 1'b0;
    unique case (c0_q.clock_select)
      3'h0: begin
        div = `STM_DIV_SYS4;
        tick = (pre_q == div - 8'h01);
      end
      3'h1: tick = 1'b1;
      3'h2: begin
        div = `STM_DIV_H16;
        tick = high_tick_i & (pre_q == div - 8'h01);
      end
      3'h3: begin
        div = `STM_DIV_H64;
        tick = high_tick_i & (pre_q == div - 8'h01);
      end
      3'h4, 3'h5: tick = sub_tick_i;
      3'h6: tick = ext_q[1] & ~ext_q[2];
      3'h7: tick = ~ext_q[1] & ext_q[2];
    endcase
  end

  // prescaler advances on its own source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= 8'h00;
    end else if (ce_i) begin
      if (c0_q.clock_select == 3'h0 || high_tick_i) begin
        pre_q <= (pre_q >= div - 8'h01) ? 8'h00 : pre_q + 8'h01;
      end
    end
  end

  // -----------------------------------------------------------------------
  // comparators
  // -----------------------------------------------------------------------
  // p matches the top three bits at field minus one with the low seven bits all ones; zero means full-range overflow
  assign match_p = tick & ((c0_q.period_field == 3'h0) ? (cnt_q == 10'h3FF) :
                   (cnt_q[9:7] == c0_q.period_field - 3'h1 && cnt_q[6:0] == 7'h7F));
  assign match_a = tick & (cnt_q == cmpa_q - 10'h001) & (cmpa_q != 10'h000);
  assign per_len = (c0_q.period_field == 3'h0) ? `STM_FULL_PERIOD :
                   {1'b0, c0_q.period_field, 7'h00};

  // clear source: pwm follows the swap bit, capture the overflow, else clear_select
  always_comb begin
    clr_a = 1'b0;
    clr_p = 1'b0;
    unique case (c1_q.mode_field)
      STM_MODE_PWM: begin
        clr_a = c1_q.duty_period_swap & match_a;
        clr_p = ~c1_q.duty_period_swap & match_p;
      end
      STM_MODE_CAP: clr_p = tick & (cnt_q == 10'h3FF);
      default: begin
        clr_a = c1_q.clear_select & match_a;
        clr_p = ~c1_q.clear_select & match_p;
      end
    endcase
  end

  // requests only while the counter really runs: a stopped, paused or frozen
  // counter would otherwise repeat the same request on every tick
  assign irq_run = ce_i & c0_q.timer_on_control & ~c0_q.pause_control;
  assign irq_a_o = irq_run & (clr_a | (match_a & ~clr_p));
  assign irq_p_o = irq_run & clr_p;

  // -----------------------------------------------------------------------
  // counter
  // -----------------------------------------------------------------------
  // the only software effect on the count is the on rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 10'h000;
    end else if (ce_i) begin
      if (on_rise) begin
        cnt_q <= 10'h000;
      end else if (c0_q.timer_on_control && !c0_q.pause_control && tick) begin
        cnt_q <= (clr_a | clr_p) ? 10'h000 : cnt_q + 10'h001;
      end
    end
  end

  // -----------------------------------------------------------------------
  // output pin logic
  // -----------------------------------------------------------------------
  assign duty_len = c1_q.duty_period_swap ? per_len : {1'b0, cmpa_q};
  assign pwm_act = ({1'b0, cnt_q} < duty_len); // duty >= period gives 100%

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
      pulse_q <= 1'b0;
    end else if (ce_i) begin
      unique case (c1_q.mode_field)
        STM_MODE_CMP: begin
          if (on_rise) begin
            out_q <= c1_q.output_control_bit;
          end else if (irq_a_o && c0_q.timer_on_control && !c0_q.pause_control) begin
            // a level request equal to the present level is invisible
            unique case (c1_q.pin_action_field)
              2'h0: out_q <= out_q;
              2'h1: out_q <= 1'b0;
              2'h2: out_q <= 1'b1;
              2'h3: out_q <= ~out_q;
            endcase
          end
        end
        STM_MODE_PWM: begin
          // single pulse starts on turn-on, ends at compare a
          if (on_rise) begin
            pulse_q <= 1'b1;
          end else if (match_a) begin
            pulse_q <= 1'b0;
          end
          unique case (c1_q.pin_action_field)
            2'h0: out_q <= 1'b0;
            2'h1: out_q <= 1'b1;
            2'h2: out_q <= pwm_act & c0_q.timer_on_control;
            2'h3: out_q <= pulse_q & c0_q.timer_on_control;
          endcase
        end
        default: out_q <= out_q;
      endcase
    end
  end

  // active level applies in pwm mode, polarity outside timer/counter mode
  always_comb begin
    pins_o.timer_output_pin = out_q;
    if (c1_q.mode_field == STM_MODE_PWM) begin
      pins_o.timer_output_pin = out_q ~^ c1_q.output_control_bit;
    end else if (c1_q.mode_field == STM_MODE_CMP) begin
      pins_o.timer_output_pin = out_q;
    end
    if (c1_q.mode_field != STM_MODE_TMR) begin
      pins_o.timer_output_pin = pins_o.timer_output_pin ^ c1_q.polarity_bit;
    end
    pins_o.complementary_output_pin = ~pins_o.timer_output_pin;
  end

  // -----------------------------------------------------------------------
  // capture edge
  // -----------------------------------------------------------------------
  always_comb begin
    unique case (c1_q.pin_action_field)
      2'h0: cap_ev = capin_q[1] & ~capin_q[2];
      2'h1: cap_ev = ~capin_q[1] & capin_q[2];
      2'h2: cap_ev = capin_q[1] ^ capin_q[2];
      2'h3: cap_ev = 1'b0;
    endcase
    cap_ev = cap_ev & (c1_q.mode_field == STM_MODE_CAP) & c0_q.timer_on_control;
  end
  assign cap_q = cnt_q;

  // -----------------------------------------------------------------------
  // registers: controls, compare a, holding buffer
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c0_q <= `STM_RST_CTRL;
      c1_q <= `STM_RST_CTRL;
      on_d1_q <= 1'b0;
    end else if (ce_i) begin
      on_d1_q <= c0_q.timer_on_control;
      if (wr && adr_i == `STM_OFS_CTRL0) begin
        c0_q <= dat_i[7:0];
      end
      if (wr && adr_i == `STM_OFS_CTRL1) begin
        c1_q <= dat_i[7:0]; // mode change expected only while off
      end
    end
  end

  // capture overrides a software high write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmpa_q <= 10'h000;
      hold_q <= 8'h00;
    end else if (ce_i) begin
      if (cap_ev) begin
        cmpa_q <= cap_q;
      end else if (wr && adr_i == `STM_OFS_CMPA_HI) begin
        cmpa_q <= {dat_i[1:0], hold_q};
      end
      if (wr && adr_i == `STM_OFS_CMPA_LO) begin
        hold_q <= dat_i[7:0];
      end else if (rd && adr_i == `STM_OFS_CNT_HI) begin
        hold_q <= cnt_q[7:0];
      end else if (rd && adr_i == `STM_OFS_CMPA_HI) begin
        hold_q <= cmpa_q[7:0];
      end
    end
  end

  // -----------------------------------------------------------------------
  // wishbone read and answer
  // -----------------------------------------------------------------------
  always_comb begin
    unique case (adr_i)
      `STM_OFS_CTRL0: rdat = c0_q;
      `STM_OFS_CTRL1: rdat = c1_q;
      `STM_OFS_CNT_LO: rdat = hold_q;
      `STM_OFS_CNT_HI: rdat = {6'h00, cnt_q[9:8]};
      `STM_OFS_CMPA_LO: rdat = hold_q;
      `STM_OFS_CMPA_HI: rdat = {6'h00, cmpa_q[9:8]};
      `STM_OFS_STATUS: rdat = {6'h00, out_q, pulse_q};
      default: rdat = 8'h00; // unmapped reads zero
    endcase
  end

  // one wait state: ack the cycle after the request, drop next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= cyc_i & stb_i & ~ack_q;
      if (rd) begin
        dat_o <= {24'h00_0000, rdat};
      end
    end
  end
  assign ack_o = ack_q;

  // -----------------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------------
  a_comp_pin_inverse: assert property (@(posedge clk_i) disable iff (rst_i)
    pins_o.complementary_output_pin != pins_o.timer_output_pin)
    else $error("complementary pin not inverse");
  a_on_clears_count: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && on_rise |=> cnt_q == 10'h000)
    else $error("turn-on did not clear counter");
  a_pause_holds_count: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && c0_q.pause_control && !on_rise |=> $stable(cnt_q))
    else $error("counter moved while paused");
  a_off_holds_count: assert property (@(posedge clk_i) disable iff (rst_i)
    !c0_q.timer_on_control && !on_rise |=> $stable(cnt_q))
    else $error("counter moved while off");
  a_cmp_init_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && on_rise && c1_q.mode_field == STM_MODE_CMP && !wr |=> out_q == $past(c1_q.output_control_bit))
    else $error("initial level not restored");
  a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tick && c0_q.timer_on_control && !c0_q.pause_control && !on_rise && !clr_a && !clr_p
    |=> cnt_q == $past(cnt_q) + 10'h001)
    else $error("counter did not advance");
  a_clear_on_match: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (clr_a || clr_p) && c0_q.timer_on_control && !c0_q.pause_control |=> cnt_q == 10'h000)
    else $error("counter not cleared on match");
  a_hold_on_high_rd: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd && adr_i == `STM_OFS_CNT_HI && !(wr) |=> hold_q == $past(cnt_q[7:0]))
    else $error("low byte not latched on high read");
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_irq_p_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && irq_p_o && !on_rise |=> cnt_q == 10'h000)
    else $error("period request without counter clear");
  a_capture_loads: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cap_ev |=> cmpa_q == $past(cnt_q))
    else $error("capture did not load the count");

endmodule : stm_timer
`default_nettype wire

// file: stm_partner.sv
// far side of the timer pins: external clock source and capture signal
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ps
`default_nettype none

module stm_partner (
  input wire logic clk_i,
  output logic ext_clk_o,
  output logic cap_o
);
  // both pins start low; ext_clk_o rests low between bursts, cap_o at its last level
  initial begin
    ext_clk_o = 1'b0;
    cap_o = 1'b0;
  end

  // each level held four cycles so a 2-ff synchroniser sees every edge
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_clk_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : pulses

  // one capture level change, then settle time
  task automatic cap(input logic v);
    @(posedge clk_i);
    cap_o <= v;
    repeat (4) @(posedge clk_i);
  endtask : cap
endmodule : stm_partner

`default_nettype wire

// file: tb_top.sv
// self-checking bench for the 10-bit timer
// assumes stm_partner drives the pins and a 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "stm_params.svh"

module tb_top;
  import stm_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk_i, rst_i, cyc, stb, we, ack, irq_a, irq_p, ext_clk, cap, e;
  logic ce = 1'b1; // clock enable, dropped once to check the freeze
  logic [3:0] sel = 4'hF; // byte lanes, lane zero dropped once
  logic [9:0] d0; // counter gap without a frozen stretch
  int na = 0; // compare a requests seen
  int na0; // request count before a burst
  logic [5:0] adr;
  logic [31:0] dat_w, dat_r;
  logic [31:0] rnd = 32'h0; // random source, also feeds the tick strobes
  stm_pins_s pins;
  int fails, n_tests, seed, j, n;
  logic [7:0] r8, c1;
  logic [9:0] v1, v2;
  logic [7:0] pc0 [4] = '{8'h19, 8'h18, 8'h09, 8'h1F};
  int pexp [4] = '{128, 1024, 512, 896};
  logic [7:0] pw_c [6] = '{8'hA8, 8'hA2, 8'h8C, 8'h98, 8'hAC, 8'hB8};
  logic [9:0] pw_a [6] = '{32, 200, 32, 32, 32, 32};
  int pw_w [6] = '{1024, 1000, 1024, 1024, 1024, 1024};
  int pw_e [6] = '{256, 360, 1024, 1024, 768, 0};

  stm_timer stm_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .high_tick_i(rnd[0]),
    .sub_tick_i(rnd[1]), .external_clock_pin_i(ext_clk), .capture_input_pin_i(cap), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
    .pins_o(pins), .irq_a_o(irq_a), .irq_p_o(irq_p));
  stm_partner stm_partner_inst (.clk_i(clk_i), .ext_clk_o(ext_clk), .cap_o(cap));

  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // fresh random word every rising edge
  always @(posedge clk_i) begin
    rnd <= $random(seed);
  end

  // compare a requests, counted for the match scenario
  always @(posedge clk_i) begin
    if (irq_a === 1'b1) begin
      na <= na + 1;
    end
  end

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // one classic cycle; waits for ack with a bound
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] r);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h0, d};
    for (k = 0; k < 64; k++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (k == 64) begin
      fails++;
      final_report();
    end
    r = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] t;
    wb(1'b1, a, d, t);
  endtask : wr

  // high byte first: it latches the low byte into the buffer
  task automatic rd10(input logic [5:0] hi, output logic [9:0] v);
    logic [7:0] h, l;
    wb(1'b0, hi, 8'h00, h);
    wb(1'b0, hi - 6'h04, 8'h00, l);
    v = {h[1:0], l};
  endtask : rd10

  // low byte parks in the buffer until the high write
  task automatic wr_cmpa(input logic [9:0] v);
    wr(`STM_OFS_CMPA_LO, v[7:0]);
    wr(`STM_OFS_CMPA_HI, {6'h00, v[9:8]});
  endtask : wr_cmpa

  task automatic chk_reg(input string nm, input logic [9:0] x, input logic [9:0] g);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input string nm, input logic x, input logic g);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", nm, x, g);
    end
  endtask : chk_pin

  task automatic chk_cnt(input string nm, input int x, input int g);
    n_tests++;
    if (g != x) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, x, g);
    end
  endtask : chk_cnt

  // cycles until the next period strobe, bounded
  task automatic wait_p(output int c);
    for (c = 1; c <= 3000; c++) begin
      @(posedge clk_i);
      if (irq_p === 1'b1) break;
    end
    if (c > 3000) begin
      fails++;
      final_report();
    end
  endtask : wait_p

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    fails++;
    final_report();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {rst_i, cyc, stb, we, adr, dat_w} = {1'b1, 41'h0};
    fails = 0;
    n_tests = 0;
    seed = 32'h4cadc20d;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset levels, unmapped place, control readback
    wb(1'b0, `STM_OFS_CTRL0, 8'h00, r8);
    chk_reg("ctrl0_rst", 10'h000, {2'b00, r8});
    chk_pin("out_rst", 1'b0, pins.timer_output_pin);
    chk_pin("comp_rst", 1'b1, pins.complementary_output_pin);
    wr(6'h1C, rnd[7:0]);
    wb(1'b0, 6'h1C, 8'h00, r8);
    chk_reg("unmapped", 10'h000, {2'b00, r8});
    c1 = rnd[15:8];
    wr(`STM_OFS_CTRL1, c1); // timer is off, so a mode change is allowed
    wb(1'b0, `STM_OFS_CTRL1, 8'h00, r8);
    chk_reg("ctrl1_rw", {2'b00, c1}, {2'b00, r8});
    // byte lane zero off: the write is acked but must not land
    sel <= 4'hE;
    wr(`STM_OFS_CTRL1, ~c1);
    sel <= 4'hF;
    wb(1'b0, `STM_OFS_CTRL1, 8'h00, r8);
    chk_reg("ctrl1_sel", {2'b00, c1}, {2'b00, r8});
    // pause freezes, off holds, on-rise zeroes
    wr(`STM_OFS_CTRL1, 8'hC0);
    wr(`STM_OFS_CTRL0, 8'h18);
    repeat (50) @(posedge clk_i);
    wr(`STM_OFS_CTRL0, 8'h98);
    rd10(`STM_OFS_CNT_HI, v1);
    repeat (20) @(posedge clk_i);
    rd10(`STM_OFS_CNT_HI, v2);
    chk_reg("cnt_pause", v1, v2);
    wr(`STM_OFS_CTRL0, 8'h18);
    repeat (30) @(posedge clk_i);
    // same read gap twice, the second with 20 frozen cycles inside it
    for (j = 0; j < 2; j++) begin
      rd10(`STM_OFS_CNT_HI, v1);
      ce <= ~j[0];
      repeat (20) @(posedge clk_i);
      ce <= 1'b1;
      rd10(`STM_OFS_CNT_HI, v2);
      if (j == 0) begin
        d0 = v2 - v1;
      end
    end
    chk_reg("ce_freeze", d0 - 10'h014, v2 - v1);
    wr(`STM_OFS_CTRL0, 8'h10);
    rd10(`STM_OFS_CNT_HI, v1);
    repeat (20) @(posedge clk_i);
    rd10(`STM_OFS_CNT_HI, v2);
    chk_reg("cnt_off", v1, v2);
    wr(`STM_OFS_CTRL0, 8'h98);
    rd10(`STM_OFS_CNT_HI, v2);
    chk_reg("cnt_zero", 10'h000, v2);
    // pin edges counted once each, rising then falling select
    for (j = 0; j < 2; j++) begin
      wr(`STM_OFS_CTRL0, 8'h00);
      wr(`STM_OFS_CTRL0, j[0] ? 8'h78 : 8'h68);
      stm_partner_inst.pulses(3 + 4 * j);
      rd10(`STM_OFS_CNT_HI, v1);
      chk_reg("ext_count", 10'(3 + 4 * j), v1);
    end
    // compare match pin actions, every action with both initial levels
    wr_cmpa(10'h003);
    rd10(`STM_OFS_CMPA_HI, v1);
    chk_reg("cmpa_rw", 10'h003, v1);
    for (j = 0; j < 8; j++) begin
      c1 = {2'b00, j[1:0], j[2], rnd[2], 2'b01};
      wr(`STM_OFS_CTRL0, 8'h60);
      wr(`STM_OFS_CTRL1, c1);
      wr(`STM_OFS_CTRL0, 8'h68);
      @(posedge clk_i); // the registered level shows one edge after the on edge
      chk_pin("init_lvl", c1[3] ^ c1[2], pins.timer_output_pin);
      case (j[1:0])
        2'b00: e = c1[3];
        2'b01: e = 1'b0;
        2'b10: e = 1'b1;
        default: e = ~c1[3];
      endcase
      e = e ^ c1[2];
      na0 = na;
      stm_partner_inst.pulses(3);
      chk_cnt("irq_a", 1, na - na0);
      chk_pin("match_lvl", e, pins.timer_output_pin);
      chk_pin("comp_lvl", ~e, pins.complementary_output_pin);
      rd10(`STM_OFS_CNT_HI, v1);
      chk_reg("cnt_clr_a", 10'h000, v1);
    end
    // capture edge choices, count moves one between the two edges
    for (j = 0; j < 4; j++) begin
      wr(`STM_OFS_CTRL0, 8'h60);
      wr(`STM_OFS_CTRL1, {2'b01, j[1:0], 4'h1});
      wr_cmpa(10'h3FF);
      wr(`STM_OFS_CTRL0, 8'h68);
      stm_partner_inst.pulses(j + 2);
      stm_partner_inst.cap(1'b1);
      stm_partner_inst.pulses(1);
      stm_partner_inst.cap(1'b0);
      rd10(`STM_OFS_CMPA_HI, v1);
      chk_reg("capture", (j == 3) ? 10'h3FF : 10'(j + 2 + (j > 0)), v1);
    end
    // period strobe spacing per field and clock choice
    wr(`STM_OFS_CTRL1, 8'hC0);
    for (j = 0; j < 4; j++) begin
      wr(`STM_OFS_CTRL0, 8'h00);
      wr(`STM_OFS_CTRL0, pc0[j]);
      wait_p(n);
      wait_p(n);
      chk_cnt("period", pexp[j], n);
    end
    // pwm: high time over whole periods, forced levels, single pulse
    for (j = 0; j < 6; j++) begin
      wr(`STM_OFS_CTRL0, 8'h11); // pin action changed only while off
      wr(`STM_OFS_CTRL1, pw_c[j]);
      wr_cmpa(pw_a[j]);
      wr(`STM_OFS_CTRL0, 8'h19);
      repeat (300) @(posedge clk_i);
      n = 0;
      repeat (pw_w[j]) begin
        @(posedge clk_i);
        if (pins.timer_output_pin === 1'b1) n++;
      end
      chk_cnt("pwm_high", pw_e[j], n);
    end
    final_report();
  end
endmodule : tb_top

`default_nettype wire
